// *** design/bbct_sequencer.sv ***
`default_nettype none
// Function
// - totals include read, prefetch, write cycles
// - five-byte field takes two operand cycles
// - field within four bytes: one cycle
// - memory field ops 16 or 24 clocks
// - taken branch 3, 6 or 9
// - expired decrement branch 7, 10, 10
// - live decrement branch 3, 6, 9
// - copying module call 63, 65, 71 plus 6n
// - plain module call 48, 50, 56
// - jumps add jump address time
// - two-bound check 16, 18, 18, plus address time
// - address loads add address time
// - single-bound check 8 plus address time
module bbct_sequencer (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // request
  input wire logic req_valid,
  output logic req_ready,
  input wire bbct_pkg::bbct_req_t req,
  // result
  output logic busy,
  output logic done,
  output bbct_pkg::bbct_time_t result_reg,
  // bus cycle slots
  output logic slot_rd,
  output logic slot_pf,
  output logic slot_wr
);
  import bbct_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef enum logic [1:0] {
    BBCT_S_IDLE,
    BBCT_S_LOOK,
    BBCT_S_RUN
  } bbct_state_t;

  bbct_state_t state_reg;
  bbct_state_t state_next;
  bbct_time_t base;
  bbct_time_t sum_next;
  logic [7:0] ea_reg;
  logic [7:0] n_reg;
  logic add_n_reg;
  logic accept;
  logic five;
  logic last;
  logic [BBCT_TOT_W-1:0] remain;
  logic [BBCT_TOT_W-1:0] idx;

  assign accept = req_valid && req_ready;
  assign req_ready = (state_reg == BBCT_S_IDLE);
  assign busy = (state_reg != BBCT_S_IDLE);

  // span over 32 bits from byte start
  assign five = bbct_five_bytes(req.bit_off, req.width);

  // ****************************************
  // lookup and cycle count
  // ****************************************
  bbct_table u_table (
    .core_clk(core_clk),
    .rstn(rstn),
    .load(accept),
    .op(req.op),
    .src(req.src),
    .mem(req.mem),
    .five(five),
    .base_reg(base)
  );

  bbct_counter u_count (
    .core_clk(core_clk),
    .rstn(rstn),
    .load(state_reg == BBCT_S_LOOK),
    .load_val(sum_next.total),
    .remain_reg(remain),
    .last(last)
  );

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ea_reg <= '0;
      n_reg <= '0;
      add_n_reg <= 1'b0;
    end else if (accept) begin
      // added address time, never below one clock total
      ea_reg <= req.ea_time;
      n_reg <= req.n;
      add_n_reg <= (req.op == BBCT_OP_CALL_COPY);
    end
  end

  // sum built from the table plus extras
  always_comb begin
    sum_next = base;
    // address time on every form that takes one
    sum_next.total = base.total + BBCT_TOT_W'(ea_reg);
    if (add_n_reg) begin
      // six clocks, one read, one write per transfer
      sum_next.total = sum_next.total
                     + BBCT_TOT_W'(BBCT_CALL_N_CLK * int'(n_reg));
      sum_next.rd = base.rd + BBCT_BUS_W'(n_reg);
      sum_next.wr = base.wr + BBCT_BUS_W'(n_reg);
    end
  end

  // ****************************************
  // sequencing
  // ****************************************
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      BBCT_S_IDLE: if (accept) state_next = BBCT_S_LOOK;
      BBCT_S_LOOK: state_next = BBCT_S_RUN;
      BBCT_S_RUN: if (last) state_next = BBCT_S_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= BBCT_S_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      result_reg <= '0;
    end else if (state_reg == BBCT_S_LOOK) begin
      result_reg <= sum_next;
    end
  end

  assign done = (state_reg == BBCT_S_RUN) && last;

  // reads lead, prefetches follow, writes close the run
  assign idx = result_reg.total - remain;
  always_comb begin
    slot_rd = 1'b0;
    slot_pf = 1'b0;
    slot_wr = 1'b0;
    if (state_reg == BBCT_S_RUN) begin
      if (idx < BBCT_TOT_W'(result_reg.rd)) begin
        slot_rd = 1'b1;
      end else if (idx < BBCT_TOT_W'(result_reg.rd + result_reg.pf)) begin
        slot_pf = 1'b1;
      end
      // writes sit at the tail so read data is back first
      if (remain <= BBCT_TOT_W'(result_reg.wr)) begin
        slot_wr = 1'b1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [BBCT_TOT_W-1:0] run_cyc;
  logic [BBCT_BUS_W-1:0] rd_cnt;
  logic [BBCT_BUS_W-1:0] pf_cnt;
  logic [BBCT_BUS_W-1:0] wr_cnt;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      run_cyc <= '0;
      rd_cnt <= '0;
      pf_cnt <= '0;
      wr_cnt <= '0;
    end else if (state_reg != BBCT_S_RUN) begin
      run_cyc <= '0;
      rd_cnt <= '0;
      pf_cnt <= '0;
      wr_cnt <= '0;
    end else begin
      run_cyc <= run_cyc + BBCT_TOT_W'(1);
      rd_cnt <= rd_cnt + BBCT_BUS_W'(slot_rd);
      pf_cnt <= pf_cnt + BBCT_BUS_W'(slot_pf);
      wr_cnt <= wr_cnt + BBCT_BUS_W'(slot_wr);
    end
  end

  a_run_length: assert property (
    @(posedge core_clk) disable iff (!rstn)
    done |-> (run_cyc + BBCT_TOT_W'(1)) == result_reg.total)
    else $error("run length differs from reported total");

  a_slot_counts: assert property (
    @(posedge core_clk) disable iff (!rstn)
    done |-> (rd_cnt + BBCT_BUS_W'(slot_rd)) == result_reg.rd
          && (pf_cnt + BBCT_BUS_W'(slot_pf)) == result_reg.pf
          && (wr_cnt + BBCT_BUS_W'(slot_wr)) == result_reg.wr)
    else $error("bus slot counts differ from reported split");

  a_five_byte: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.mem && req.op == BBCT_OP_FIELD_SET && five
    |-> ##2 result_reg.rd == BBCT_BUS_W'(2))
    else $error("five-byte field not read twice");

  a_four_byte: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.mem && req.op == BBCT_OP_FIELD_CLEAR
    && req.width == 6'h00 && req.bit_off == 3'h0
    |-> ##2 result_reg.rd == BBCT_BUS_W'(1))
    else $error("aligned 32-bit field not read once");

  a_field_total: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.mem && req.op == BBCT_OP_FIELD_INVERT && five
    |-> ##2 result_reg.total
        == BBCT_TOT_W'(24) + BBCT_TOT_W'($past(req.ea_time, 2)))
    else $error("five-byte field invert not 24 plus address");

  a_branch_worst: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.op == BBCT_OP_BRANCH_TAKEN
    && req.src == BBCT_SRC_EXTERNAL && req.ea_time == 8'h00
    |-> ##2 result_reg.total == BBCT_TOT_W'(9)
        && result_reg.pf == BBCT_BUS_W'(2) ##9 !busy)
    else $error("taken branch worst case not 9 clocks");

  a_dec_expired: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.op == BBCT_OP_DEC_EXPIRED
    && req.src == BBCT_SRC_OVERLAP && req.ea_time == 8'h00
    |-> ##2 busy [*7] ##1 !busy)
    else $error("expired decrement branch not 7 clocks");

  a_dec_live: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.op == BBCT_OP_DEC_LIVE
    && req.src == BBCT_SRC_EXTERNAL && req.ea_time == 8'h00
    |-> ##2 result_reg.total == BBCT_TOT_W'(9)
        && result_reg.pf == BBCT_BUS_W'(2))
    else $error("live decrement branch worst case not 9");

  a_call_copy: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.op == BBCT_OP_CALL_COPY && req.src == BBCT_SRC_OVERLAP
    |-> ##2 result_reg.total == BBCT_TOT_W'(63)
          + BBCT_TOT_W'(6 * int'($past(req.n, 2)))
          + BBCT_TOT_W'($past(req.ea_time, 2))
        && result_reg.rd == BBCT_BUS_W'(7) + BBCT_BUS_W'($past(req.n, 2)))
    else $error("copying call duration wrong");

  a_call_nocopy: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.op == BBCT_OP_CALL_NOCOPY && req.src == BBCT_SRC_CACHE
    |-> ##2 result_reg.total
        == BBCT_TOT_W'(50) + BBCT_TOT_W'($past(req.ea_time, 2))
        && result_reg.rd == BBCT_BUS_W'(5)
        && result_reg.wr == BBCT_BUS_W'(8))
    else $error("plain call cache case wrong");

  a_one_bound: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.op == BBCT_OP_SINGLE_BOUND
    |-> ##2 result_reg.total
        == BBCT_TOT_W'(8) + BBCT_TOT_W'($past(req.ea_time, 2)))
    else $error("single-bound check base not 8");

  a_jump_best: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.op == BBCT_OP_JUMP && req.src == BBCT_SRC_OVERLAP
    |-> ##2 result_reg.total
        == BBCT_TOT_W'(1) + BBCT_TOT_W'($past(req.ea_time, 2)))
    else $error("jump best case not 1 plus address");

  a_jump_sub: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.op == BBCT_OP_JUMP_SUB && req.src == BBCT_SRC_EXTERNAL
    |-> ##2 result_reg.total
        == BBCT_TOT_W'(11) + BBCT_TOT_W'($past(req.ea_time, 2))
        && result_reg.pf == BBCT_BUS_W'(2)
        && result_reg.wr == BBCT_BUS_W'(1))
    else $error("subroutine jump worst case wrong");

  a_two_bound: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.op == BBCT_OP_TWO_BOUND && req.src == BBCT_SRC_OVERLAP
    |-> ##2 result_reg.total
        == BBCT_TOT_W'(16) + BBCT_TOT_W'($past(req.ea_time, 2))
        && result_reg.rd == BBCT_BUS_W'(2))
    else $error("two-bound check best case wrong");

  a_push_address: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.op == BBCT_OP_PUSH_EA && req.src == BBCT_SRC_OVERLAP
    |-> ##2 result_reg.total
        == BBCT_TOT_W'(3) + BBCT_TOT_W'($past(req.ea_time, 2))
        && result_reg.wr == BBCT_BUS_W'(1))
    else $error("address push best case wrong");

  a_branch_cache: assert property (
    @(posedge core_clk) disable iff (!rstn)
    accept && req.op == BBCT_OP_BRANCH_TAKEN
    && req.src == BBCT_SRC_CACHE && req.ea_time == 8'h00
    |-> ##2 result_reg.total == BBCT_TOT_W'(6)
        && result_reg.pf == BBCT_BUS_W'(0))
    else $error("taken branch cache case not 6 clocks");

endmodule
`default_nettype wire

// *** inc/bbct_pkg.sv ***
`default_nettype none
package bbct_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int BBCT_TOT_W = 12;
  localparam int BBCT_BUS_W = 10;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [3:0] {
    BBCT_OP_FIELD_INVERT,
    BBCT_OP_FIELD_CLEAR,
    BBCT_OP_FIELD_SET,
    BBCT_OP_BRANCH_TAKEN,
    BBCT_OP_DEC_EXPIRED,
    BBCT_OP_DEC_LIVE,
    BBCT_OP_CALL_COPY,
    BBCT_OP_CALL_NOCOPY,
    BBCT_OP_JUMP,
    BBCT_OP_JUMP_SUB,
    BBCT_OP_TWO_BOUND,
    BBCT_OP_SINGLE_BOUND,
    BBCT_OP_LOAD_EA,
    BBCT_OP_PUSH_EA
  } bbct_op_t;

  // where the instruction words come from
  typedef enum logic [1:0] {
    BBCT_SRC_OVERLAP,
    BBCT_SRC_CACHE,
    BBCT_SRC_EXTERNAL
  } bbct_src_t;

  typedef struct packed {
    logic [BBCT_TOT_W-1:0] total;
    logic [BBCT_BUS_W-1:0] rd;
    logic [BBCT_BUS_W-1:0] pf;
    logic [BBCT_BUS_W-1:0] wr;
  } bbct_time_t;

  // width 0 stands for a 32-bit field
  typedef struct packed {
    bbct_op_t op;
    bbct_src_t src;
    logic mem;
    logic [2:0] bit_off;
    logic [5:0] width;
    logic [7:0] ea_time;
    logic [7:0] n;
  } bbct_req_t;

  function automatic bbct_time_t bbct_mk(int t, int r, int p, int w);
    bbct_time_t v;
    v.total = BBCT_TOT_W'(t);
    v.rd = BBCT_BUS_W'(r);
    v.pf = BBCT_BUS_W'(p);
    v.wr = BBCT_BUS_W'(w);
    return v;
  endfunction

  // does the field reach into a fifth byte
  function automatic logic bbct_five_bytes(logic [2:0] off,
                                           logic [5:0] width);
    logic [6:0] w;
    w = (width == 6'h00) ? 7'h20 : {1'b0, width};
    return ({4'h0, off} + w) > 7'h20;
  endfunction

  // ****************************************
  // base durations: best, cache, worst
  // ****************************************
  localparam bbct_time_t BBCT_T_FLD_REG [3] =
    '{bbct_mk(9, 0, 0, 0), bbct_mk(12, 0, 0, 0), bbct_mk(12, 0, 1, 0)};
  localparam bbct_time_t BBCT_T_FLD_MEM4 [3] =
    '{bbct_mk(16, 1, 0, 1), bbct_mk(16, 1, 0, 1), bbct_mk(16, 1, 1, 1)};
  localparam bbct_time_t BBCT_T_FLD_MEM5 [3] =
    '{bbct_mk(24, 2, 0, 2), bbct_mk(24, 2, 0, 2), bbct_mk(24, 2, 1, 2)};
  localparam bbct_time_t BBCT_T_BR_TAKEN [3] =
    '{bbct_mk(3, 0, 0, 0), bbct_mk(6, 0, 0, 0), bbct_mk(9, 0, 2, 0)};
  localparam bbct_time_t BBCT_T_DEC_EXP [3] =
    '{bbct_mk(7, 0, 0, 0), bbct_mk(10, 0, 0, 0), bbct_mk(10, 0, 3, 0)};
  localparam bbct_time_t BBCT_T_DEC_LIVE [3] =
    '{bbct_mk(3, 0, 0, 0), bbct_mk(6, 0, 0, 0), bbct_mk(9, 0, 2, 0)};
  localparam bbct_time_t BBCT_T_CALL_COPY [3] =
    '{bbct_mk(63, 7, 0, 8), bbct_mk(65, 7, 0, 8), bbct_mk(71, 7, 2, 8)};
  localparam bbct_time_t BBCT_T_CALL_NOCOPY [3] =
    '{bbct_mk(48, 5, 0, 8), bbct_mk(50, 5, 0, 8), bbct_mk(56, 5, 2, 8)};
  localparam bbct_time_t BBCT_T_JUMP [3] =
    '{bbct_mk(1, 0, 0, 0), bbct_mk(4, 0, 0, 0), bbct_mk(7, 0, 2, 0)};
  localparam bbct_time_t BBCT_T_JUMP_SUB [3] =
    '{bbct_mk(3, 0, 0, 1), bbct_mk(5, 0, 0, 1), bbct_mk(11, 0, 2, 1)};
  localparam bbct_time_t BBCT_T_TWO_BOUND [3] =
    '{bbct_mk(16, 2, 0, 0), bbct_mk(18, 2, 0, 0), bbct_mk(18, 2, 1, 0)};
  localparam bbct_time_t BBCT_T_ONE_BOUND [3] =
    '{bbct_mk(8, 0, 0, 0), bbct_mk(8, 0, 0, 0), bbct_mk(8, 0, 1, 0)};
  localparam bbct_time_t BBCT_T_LOAD_EA [3] =
    '{bbct_mk(2, 0, 0, 0), bbct_mk(2, 0, 0, 0), bbct_mk(3, 0, 1, 0)};
  localparam bbct_time_t BBCT_T_PUSH_EA [3] =
    '{bbct_mk(3, 0, 0, 1), bbct_mk(5, 0, 0, 1), bbct_mk(6, 0, 1, 1)};

  // per operand transfer of a stack-copying call
  localparam int BBCT_CALL_N_CLK = 6;

endpackage
`default_nettype wire

// *** design/bbct_table.sv ***
`default_nettype none
module bbct_table (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // lookup
  input wire logic load,
  input wire bbct_pkg::bbct_op_t op,
  input wire bbct_pkg::bbct_src_t src,
  input wire logic mem,
  input wire logic five,
  output bbct_pkg::bbct_time_t base_reg
);
  import bbct_pkg::*;

  bbct_time_t base_next;
  int idx;

  always_comb begin
    idx = (src == BBCT_SRC_OVERLAP) ? 0 : (src == BBCT_SRC_CACHE) ? 1 : 2;
    base_next = BBCT_T_JUMP[idx];
    unique case (op)
      BBCT_OP_FIELD_INVERT, BBCT_OP_FIELD_CLEAR, BBCT_OP_FIELD_SET: begin
        if (!mem) base_next = BBCT_T_FLD_REG[idx];
        else if (five) base_next = BBCT_T_FLD_MEM5[idx];
        else base_next = BBCT_T_FLD_MEM4[idx];
      end
      BBCT_OP_BRANCH_TAKEN: base_next = BBCT_T_BR_TAKEN[idx];
      BBCT_OP_DEC_EXPIRED: base_next = BBCT_T_DEC_EXP[idx];
      BBCT_OP_DEC_LIVE: base_next = BBCT_T_DEC_LIVE[idx];
      BBCT_OP_CALL_COPY: base_next = BBCT_T_CALL_COPY[idx];
      BBCT_OP_CALL_NOCOPY: base_next = BBCT_T_CALL_NOCOPY[idx];
      BBCT_OP_JUMP: base_next = BBCT_T_JUMP[idx];
      BBCT_OP_JUMP_SUB: base_next = BBCT_T_JUMP_SUB[idx];
      BBCT_OP_TWO_BOUND: base_next = BBCT_T_TWO_BOUND[idx];
      BBCT_OP_SINGLE_BOUND: base_next = BBCT_T_ONE_BOUND[idx];
      BBCT_OP_LOAD_EA: base_next = BBCT_T_LOAD_EA[idx];
      BBCT_OP_PUSH_EA: base_next = BBCT_T_PUSH_EA[idx];
      default: base_next = BBCT_T_JUMP[idx];
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      base_reg <= '0;
    end else if (load) begin
      base_reg <= base_next;
    end
  end

endmodule
`default_nettype wire

// *** design/bbct_counter.sv ***
`default_nettype none
module bbct_counter (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control
  input wire logic load,
  input wire logic [bbct_pkg::BBCT_TOT_W-1:0] load_val,
  // state
  output logic [bbct_pkg::BBCT_TOT_W-1:0] remain_reg,
  output logic last
);
  import bbct_pkg::*;

  assign last = (remain_reg == BBCT_TOT_W'(1));

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      remain_reg <= '0;
    end else if (load) begin
      remain_reg <= load_val;
    end else if (remain_reg != '0) begin
      remain_reg <= remain_reg - BBCT_TOT_W'(1);
    end
  end

endmodule
`default_nettype wire

// *** testbench/test_bbct_sequencer.sv ***
`default_nettype none
module test_bbct_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import bbct_pkg::*;

  logic core_clk;
  logic rstn;
  logic req_valid;
  logic req_ready;
  bbct_req_t req;
  logic busy;
  logic done;
  bbct_time_t result_reg;
  logic slot_rd;
  logic slot_pf;
  logic slot_wr;
  int err_count = 0;
  int compares = 0;

  bbct_sequencer dut (
    .core_clk(core_clk),
    .rstn(rstn),
    .req_valid(req_valid),
    .req_ready(req_ready),
    .req(req),
    .busy(busy),
    .done(done),
    .result_reg(result_reg),
    .slot_rd(slot_rd),
    .slot_pf(slot_pf),
    .slot_wr(slot_wr)
  );

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ****************************************
  // checking
  // ****************************************
  task automatic chk(string nm, logic [11:0] e, logic [11:0] g);
    compares++;
    if (g !== e) begin
      err_count++;
      $display("wrong value %s expected %0d seen %0d", nm, e, g);
    end
  endtask

  task automatic close_out;
    if (err_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // one instruction: accept, run, compare totals and slot counts
  // lg keeps req_valid up into the busy span with another op
  task automatic do_op(bbct_op_t op, bbct_src_t s, logic m, logic [2:0] o,
                       logic [5:0] w, int ea, int n, int t, int r, int p,
                       int wr, bit lg);
    int nr, np, nw, nd, dc;
    nr = 0;
    np = 0;
    nw = 0;
    nd = 0;
    dc = 0;
    @(negedge core_clk);
    req_valid = 1'b1;
    req = '{op, s, m, o, w, 8'(ea), 8'(n)};
    chk("ready idle", 12'h001, {11'h000, req_ready});
    @(posedge core_clk);
    for (int c = 1; c <= t + 1; c++) begin
      @(negedge core_clk);
      if (!lg || c == 3)
        req_valid = 1'b0;
      if (lg && c == 1)
        req.op = BBCT_OP_CALL_NOCOPY;
      chk("busy", 12'h001, {11'h000, busy});
      nr += int'(slot_rd === 1'b1);
      np += int'(slot_pf === 1'b1);
      nw += int'(slot_wr === 1'b1);
      if (done === 1'b1) begin
        nd++;
        dc = c;
      end
    end
    @(negedge core_clk);
    chk("ready after", 12'h001, {11'h000, req_ready});
    chk("busy after", 12'h000, {11'h000, busy});
    chk("total", 12'(t), result_reg.total);
    chk("reads", 12'(r), {2'h0, result_reg.rd});
    chk("prefetches", 12'(p), {2'h0, result_reg.pf});
    chk("writes", 12'(wr), {2'h0, result_reg.wr});
    chk("read slots", 12'(r), 12'(nr));
    chk("prefetch slots", 12'(p), 12'(np));
    chk("write slots", 12'(wr), 12'(nw));
    chk("done pulses", 12'h001, 12'(nd));
    chk("done cycle", 12'(t + 1), 12'(dc));
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_field;
    bbct_op_t op;
    bbct_src_t s;
    int p;
    for (int k = 0; k < 3; k++) begin
      op = bbct_op_t'(k);
      for (int i = 0; i < 3; i++) begin
        s = bbct_src_t'(i);
        p = (i == 2) ? 1 : 0;
        do_op(op, s, 1'b1, 3'h0, 6'h00, 0, 0, 16, 1, p, 1, 0);
        do_op(op, s, 1'b1, 3'h1, 6'h00, 5, 0, 29, 2, p, 2, 0);
      end
      do_op(op, BBCT_SRC_OVERLAP, 1'b1, 3'h7, 6'h19, 0, 0, 16, 1, 0, 1,
            0);
      do_op(op, BBCT_SRC_OVERLAP, 1'b1, 3'h7, 6'h1a, 0, 0, 24, 2, 0, 2,
            0);
    end
  endtask

  task automatic t_branch;
    int tb[3] = '{3, 6, 9};
    int pb[3] = '{0, 0, 2};
    int te[3] = '{7, 10, 10};
    int pe[3] = '{0, 0, 3};
    bbct_src_t s;
    for (int i = 0; i < 3; i++) begin
      s = bbct_src_t'(i);
      do_op(BBCT_OP_BRANCH_TAKEN, s, 1'b0, 3'h0, 6'h00, 0, 0, tb[i], 0,
            pb[i], 0, 0);
      do_op(BBCT_OP_DEC_EXPIRED, s, 1'b0, 3'h0, 6'h00, 0, 0, te[i], 0,
            pe[i], 0, 0);
      do_op(BBCT_OP_DEC_LIVE, s, 1'b0, 3'h0, 6'h00, 0, 0, tb[i], 0,
            pb[i], 0, 0);
    end
  endtask

  task automatic t_call;
    int tc[3] = '{63, 65, 71};
    int tn[3] = '{48, 50, 56};
    int pc[3] = '{0, 0, 2};
    bbct_src_t s;
    for (int i = 0; i < 3; i++) begin
      s = bbct_src_t'(i);
      do_op(BBCT_OP_CALL_COPY, s, 1'b0, 3'h0, 6'h00, 4, 3, tc[i] + 22,
            10, pc[i], 11, 0);
      do_op(BBCT_OP_CALL_NOCOPY, s, 1'b0, 3'h0, 6'h00, 0, 0, tn[i], 5,
            pc[i], 8, 0);
    end
    do_op(BBCT_OP_CALL_COPY, BBCT_SRC_OVERLAP, 1'b0, 3'h0, 6'h00, 0, 0,
          63, 7, 0, 8, 0);
  endtask

  task automatic t_ctrl;
    int tj[3] = '{1, 4, 7};
    int ts[3] = '{3, 5, 11};
    int t2[3] = '{16, 18, 18};
    int tl[3] = '{2, 2, 3};
    int tp[3] = '{3, 5, 6};
    int p2[3] = '{0, 0, 2};
    int p1[3] = '{0, 0, 1};
    bbct_src_t s;
    for (int i = 0; i < 3; i++) begin
      s = bbct_src_t'(i);
      do_op(BBCT_OP_JUMP, s, 1'b0, 3'h0, 6'h00, 3, 0, tj[i] + 3, 0,
            p2[i], 0, 0);
      do_op(BBCT_OP_JUMP_SUB, s, 1'b0, 3'h0, 6'h00, 3, 0, ts[i] + 3, 0,
            p2[i], 1, 0);
      do_op(BBCT_OP_TWO_BOUND, s, 1'b0, 3'h0, 6'h00, 2, 0, t2[i] + 2, 2,
            p1[i], 0, 0);
      do_op(BBCT_OP_SINGLE_BOUND, s, 1'b0, 3'h0, 6'h00, 4, 0, 12, 0,
            p1[i], 0, 0);
      do_op(BBCT_OP_LOAD_EA, s, 1'b0, 3'h0, 6'h00, 6, 0, tl[i] + 6, 0,
            p1[i], 0, 0);
      do_op(BBCT_OP_PUSH_EA, s, 1'b0, 3'h0, 6'h00, 6, 0, tp[i] + 6, 0,
            p1[i], 1, 0);
    end
    do_op(BBCT_OP_JUMP, BBCT_SRC_OVERLAP, 1'b0, 3'h0, 6'h00, 0, 0, 1, 0,
          0, 0, 0);
  endtask

  // a second request held up while busy must not disturb the first
  task automatic t_refuse;
    do_op(BBCT_OP_BRANCH_TAKEN, BBCT_SRC_EXTERNAL, 1'b0, 3'h0, 6'h00, 0,
          0, 9, 0, 2, 0, 1);
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    req = '0;
    repeat (12) @(negedge core_clk);
    rstn = 1'b1;
    t_field();
    t_branch();
    t_call();
    t_ctrl();
    t_refuse();
    repeat (2) @(negedge core_clk);
    close_out();
  end

  // run takes about 1500 cycles; allow over ten times that
  initial begin
    #200000;
    err_count++;
    close_out();
  end

endmodule
`default_nettype wire
